// >>> pkg/hpamp_defines.svh
// register layout, address and timing constants of the headphone amplifier control port
`ifndef HPAMP_DEFINES_SVH
`define HPAMP_DEFINES_SVH
`define HPAMP_TARGET_ADDR 7'h60
`define HPAMP_REG_COUNT 3'h5
`define HPAMP_REG_LAST 3'h4
`define HPAMP_STAT_LSHORT 7
`define HPAMP_STAT_RSHORT 6
`define HPAMP_STAT_THERM 5
`define HPAMP_MODE_HI 6
`define HPAMP_MODE_LO 4
`define HPAMP_MUTE_L_BIT 7
`define HPAMP_MUTE_R_BIT 6
`define HPAMP_MODE_RESET 3'h0
`define HPAMP_VOL_RESET 8'hc0
`define HPAMP_VOL_MUTE_CODE 6'h00
`define HPAMP_SCL_MAX_KHZ 400
`define HPAMP_CLK_MHZ 200
`endif

// >>> pkg/hpamp_pkg.sv
// types shared by the headphone amplifier control port
package hpamp_pkg;
	typedef enum logic [5:0] {
		HPAMP_IDLE = 6'b000001,
		HPAMP_ADDR = 6'b000010,
		HPAMP_WACK = 6'b000100,
		HPAMP_WDAT = 6'b001000,
		HPAMP_RDAT = 6'b010000,
		HPAMP_RACK = 6'b100000
	} hpamp_state_t;

	// decoded amplifier controls
	typedef struct packed {
		logic left_on;
		logic right_on;
		logic supply_on;
		logic left_mute;
		logic right_mute;
		logic [5:0] left_gain;
		logic [5:0] right_gain;
	} hpamp_ctrl_t;

	typedef struct packed {
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		hpamp_state_t state;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic rnw;
		logic first_byte_done;
		logic [2:0] rd_idx;
		logic [2:0] mode;
		logic [7:0] volume;
		logic sda_oe;
		logic [7:0] ack_hold;
		hpamp_ctrl_t ctrl;
	} hpamp_regs_t;
endpackage : hpamp_pkg

// >>> hdl/hpamp_i2c_ctrl.sv
// i2c target control port of a stereo headphone amplifier
`include "hpamp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module hpamp_i2c_ctrl
	import hpamp_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'h5a, // arbitrary identification value
	parameter int SYNC_STAGES = 2
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic standby_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic left_short_flag_i,
	input wire logic right_short_flag_i,
	input wire logic thermal_shutdown_flag_i,
	output hpamp_ctrl_t ctrl_o
);
	// the sampler needs at least a handful of clocks per scl phase
	initial begin
		if (SYNC_STAGES != 2) begin
			$error("hpamp_i2c_ctrl: only two sync stages supported");
		end
		if (`HPAMP_CLK_MHZ * 1000 / `HPAMP_SCL_MAX_KHZ < 16) begin
			$error("hpamp_i2c_ctrl: clock too slow for fast-mode scl");
		end
	end

	hpamp_regs_t r, next_r;
	logic scl_rise, scl_fall, start_cond, stop_cond, scl_s, sda_s;
	logic [7:0] status_byte, rd_byte;

	// faults come from analog circuits: synchronise before they reach the bus
	logic [2:0] flag_meta, flag_sync;
	always_ff @(posedge clk_i) begin
		flag_meta <= {left_short_flag_i, right_short_flag_i, thermal_shutdown_flag_i};
		flag_sync <= flag_meta;
	end

	// bits 1 and 2 of each sync chain are the stable samples; bit 0 is the first flop only
	assign scl_s = r.scl_sync[1];
	assign sda_s = r.sda_sync[1];
	assign scl_rise = r.scl_sync[1] & ~r.scl_sync[2];
	assign scl_fall = ~r.scl_sync[1] & r.scl_sync[2];
	assign start_cond = scl_s & r.scl_sync[2] & ~sda_s & r.sda_sync[2];
	assign stop_cond = scl_s & r.scl_sync[2] & sda_s & ~r.sda_sync[2];

	// status byte with lower bits zero
	assign status_byte = {flag_sync, 5'h00};

	// read mux, every register visible
	always_comb begin
		if (r.rd_idx == 3'h0) begin
			rd_byte = status_byte;
		end else if (r.rd_idx == 3'h1) begin
			rd_byte = {1'b0, r.mode, 4'h0};
		end else if (r.rd_idx == 3'h2) begin
			rd_byte = r.volume;
		end else if (r.rd_idx == 3'h3) begin
			rd_byte = 8'h00;
		end else begin
			rd_byte = DEVICE_ID;
		end
	end

	// protocol engine; scl is input only, the target never drives it
	always_comb begin
		next_r = r;
		next_r.scl_sync = {r.scl_sync[1:0], scl_i};
		next_r.sda_sync = {r.sda_sync[1:0], sda_i};
		next_r.ack_hold = 8'h00;
		if (stop_cond) begin
			next_r.state = HPAMP_IDLE;
			next_r.sda_oe = 1'b0;
		end else if (start_cond) begin
			// also covers repeated start
			next_r.state = HPAMP_ADDR;
			next_r.bit_cnt = 4'h0;
			next_r.sda_oe = 1'b0;
			next_r.first_byte_done = 1'b0;
		end else begin
			case (r.state)
				HPAMP_IDLE: begin
					next_r.sda_oe = 1'b0;
				end
				HPAMP_ADDR, HPAMP_WDAT: begin
					if (scl_rise) begin
						next_r.shift = {r.shift[6:0], sda_s};
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end else if (scl_fall && r.bit_cnt == 4'h8) begin
						next_r.bit_cnt = 4'h0;
						if (r.state == HPAMP_ADDR) begin
							if (r.shift[7:1] == `HPAMP_TARGET_ADDR) begin
								next_r.rnw = r.shift[0];
								next_r.rd_idx = 3'h0;
								next_r.sda_oe = 1'b1;
								next_r.state = HPAMP_WACK;
							end else begin
								next_r.state = HPAMP_IDLE;
							end
						end else begin
							// no pointer byte: first write to mode, later to volume
							if (!r.first_byte_done) begin
								next_r.mode = r.shift[`HPAMP_MODE_HI:`HPAMP_MODE_LO];
								next_r.first_byte_done = 1'b1;
							end else begin
								next_r.volume = r.shift;
							end
							next_r.sda_oe = 1'b1;
							next_r.state = HPAMP_WACK;
						end
					end
				end
				HPAMP_WACK: begin
					// hold ack for the full scl high phase, release on falling edge
					if (scl_fall) begin
						next_r.sda_oe = 1'b0;
						if (r.rnw) begin
							next_r.state = HPAMP_RDAT;
							next_r.sda_oe = ~rd_byte[7];
							next_r.shift = {rd_byte[6:0], 1'b0};
							next_r.bit_cnt = 4'h1;
						end else begin
							next_r.state = HPAMP_WDAT;
						end
					end
				end
				HPAMP_RDAT: begin
					if (scl_fall) begin
						if (r.bit_cnt == 4'h8) begin
							next_r.sda_oe = 1'b0;
							next_r.state = HPAMP_RACK;
							next_r.rd_idx = (r.rd_idx == `HPAMP_REG_LAST) ? 3'h0 : r.rd_idx + 3'h1;
						end else begin
							next_r.sda_oe = ~r.shift[7];
							next_r.shift = {r.shift[6:0], 1'b0};
							next_r.bit_cnt = r.bit_cnt + 4'h1;
						end
					end
				end
				HPAMP_RACK: begin
					if (scl_rise) begin
						next_r.rnw = ~sda_s;
					end else if (scl_fall) begin
						if (r.rnw) begin
							next_r.state = HPAMP_RDAT;
							next_r.sda_oe = ~rd_byte[7];
							next_r.shift = {rd_byte[6:0], 1'b0};
							next_r.bit_cnt = 4'h1;
						end else begin
							next_r.state = HPAMP_IDLE;
						end
					end
				end
				default: begin
					next_r.state = HPAMP_IDLE;
				end
			endcase
		end
		// mode decode and mute combination
		next_r.ctrl.left_on = (r.mode == 3'h2) || (r.mode == 3'h3);
		next_r.ctrl.right_on = (r.mode == 3'h1) || (r.mode == 3'h3);
		next_r.ctrl.supply_on = (r.mode >= 3'h1) && (r.mode <= 3'h4);
		next_r.ctrl.left_mute = r.volume[`HPAMP_MUTE_L_BIT] || r.volume[5:0] == `HPAMP_VOL_MUTE_CODE;
		next_r.ctrl.right_mute = r.volume[`HPAMP_MUTE_R_BIT] || r.volume[5:0] == `HPAMP_VOL_MUTE_CODE;
		next_r.ctrl.left_gain = r.volume[5:0];
		next_r.ctrl.right_gain = r.volume[5:0];
	end

	// standby acts as a second synchronous reset: whole port goes dark
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !standby_n_i) begin
			r <= '0;
			r.scl_sync <= 3'h7;
			r.sda_sync <= 3'h7;
			r.state <= HPAMP_IDLE;
			r.mode <= `HPAMP_MODE_RESET;
			r.volume <= `HPAMP_VOL_RESET;
			r.ctrl.left_mute <= 1'b1;
			r.ctrl.right_mute <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = r.sda_oe;
	assign ctrl_o = r.ctrl;

	// assertions
	sequence addr_ack_s;
		r.state == HPAMP_ADDR && scl_fall && r.bit_cnt == 4'h8 && r.shift[7:1] == `HPAMP_TARGET_ADDR;
	endsequence

	addr_ack_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		addr_ack_s |=> r.sda_oe && r.state == HPAMP_WACK) else $error("own address not acknowledged");
	foreign_ign_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.state == HPAMP_ADDR && scl_fall && r.bit_cnt == 4'h8 && r.shift[7:1] != `HPAMP_TARGET_ADDR
		|=> r.state == HPAMP_IDLE && !r.sda_oe) else $error("foreign address answered");
	first_mode_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.state == HPAMP_WDAT && scl_fall && r.bit_cnt == 4'h8 && !r.first_byte_done
		|=> r.mode == $past(r.shift[6:4]) && $stable(r.volume)) else $error("first byte not to mode");
	next_vol_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.state == HPAMP_WDAT && scl_fall && r.bit_cnt == 4'h8 && r.first_byte_done
		|=> r.volume == $past(r.shift) && $stable(r.mode)) else $error("later byte not to volume");
	rd_wrap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.state == HPAMP_RDAT && scl_fall && r.bit_cnt == 4'h8 && r.rd_idx == 3'h4
		|=> r.rd_idx == 3'h0) else $error("read index did not wrap");
	ro_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.state == HPAMP_RDAT |=> $stable(r.mode) && $stable(r.volume)) else $error("register changed on read");
	zero_reg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.rd_idx == 3'h3 |-> rd_byte == 8'h00) else $error("register three not zero");
	nack_stop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.state == HPAMP_RACK && scl_fall && !r.rnw |=> r.state == HPAMP_IDLE ##1 !r.sda_oe)
		else $error("data driven after nack");
	standby_dark_a: assert property (@(posedge clk_i)
		!standby_n_i |=> !sda_oe_o && ctrl_o.left_mute && !ctrl_o.supply_on) else $error("active in standby");
	mode_dec_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !standby_n_i)
		r.mode == 3'h3 && $stable(r.mode) |=> ctrl_o.left_on && ctrl_o.right_on) else $error("mode decode wrong");
endmodule : hpamp_i2c_ctrl
`default_nettype wire

// >>> tb/hpamp_host_model.sv
// host-side i2c master model for the amplifier control port
`timescale 1ns/100ps
`default_nettype none
module hpamp_host_model (
	output var logic scl_o,
	output var logic sda_oe_o,
	input wire logic sda_i
);
	localparam realtime Q = 31.25; // quarter of a 125 ns bit
	// idle bus: clock parked high, data released
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// start or repeated start: data falls while the clock is high
	task automatic start();
		sda_oe_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask : start
	// stop: data rises while the clock is high, then the clock stands still
	task automatic stop();
		sda_oe_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_oe_o = 1'b0;
		#Q;
	endtask : stop
	// eight bits then the acknowledge slot; a 1 releases the line
	task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack);
		logic [8:0] s;
		logic [8:0] r;
		s = {d, ack_bit};
		r = 9'h000;
		for (int i = 8; i >= 0; i--) begin
			sda_oe_o = !s[i];
			#Q scl_o = 1'b1;
			#Q r = {r[7:0], sda_i};
			#Q scl_o = 1'b0;
			#Q;
		end
		q = r[8:1];
		ack = r[0];
	endtask : xfer
endmodule : hpamp_host_model
`default_nettype wire

// >>> tb/hpamp_i2c_ctrl_bench.sv
// self-checking bench for the amplifier control port
`timescale 1ns/100ps
`default_nettype none
module hpamp_i2c_ctrl_bench
	import hpamp_pkg::*;
;
	localparam logic [7:0] ID = 8'h3c; // arbitrary identification value
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic standby_n_i = 1'b1;
	logic [2:0] flags = 3'b100;
	logic scl, m_oe, sda_o, sda_oe, sda;
	hpamp_ctrl_t ctrl_o;
	int bad_count = 0;
	int checks_done = 0;
	logic [7:0] q;
	logic a;
	// open-drain data line with pull-up
	assign sda = !(m_oe || (sda_oe && !sda_o));
	// system clock
	always #2.5 clk_i = !clk_i;
	hpamp_i2c_ctrl #(.DEVICE_ID(ID)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .standby_n_i(standby_n_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .left_short_flag_i(flags[2]),
		.right_short_flag_i(flags[1]), .thermal_shutdown_flag_i(flags[0]), .ctrl_o(ctrl_o));
	hpamp_host_model m (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
	task automatic stop_test();
		if (bad_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp8
	// address byte, then first byte, a filler byte and a last byte
	task automatic wr(input logic [7:0] ab, input logic [7:0] d0, input logic [7:0] d1, input logic ok);
		m.start();
		m.xfer(ab, 1'b1, q, a);
		cmp8({7'h0, a}, {7'h0, !ok});
		if (ok) begin
			m.xfer(d0, 1'b1, q, a);
			cmp8({7'h0, a}, 8'h00);
			m.xfer(8'h3e, 1'b1, q, a);
			m.xfer(d1, 1'b1, q, a);
			cmp8({7'h0, a}, 8'h00);
		end
		m.stop();
	endtask : wr
	// read n bytes from register zero on, nack on the last
	task automatic rd(input logic [7:0] st, input logic [2:0] md, input logic [7:0] vol, input int n);
		logic [7:0] e [5];
		e = '{st, {1'b0, md, 4'h0}, vol, 8'h00, ID};
		m.start();
		m.xfer(8'hc1, 1'b1, q, a);
		cmp8({7'h0, a}, 8'h00);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hff, i == n - 1, q, a);
			cmp8(q, e[i % 5]);
		end
		cmp8({7'h0, sda_oe}, 8'h00);
		m.stop();
	endtask : rd
	// decoded controls; code zero also mutes
	task automatic chk_ctrl(input logic [2:0] md, input logic [7:0] vol);
		logic [4:0] e;
		e[4] = md == 3'h2 || md == 3'h3;
		e[3] = md == 3'h1 || md == 3'h3;
		e[2] = md inside {[3'h1:3'h4]};
		e[1] = vol[7] || vol[5:0] == 6'h00;
		e[0] = vol[6] || vol[5:0] == 6'h00;
		cmp8({3'h0, ctrl_o.left_on, ctrl_o.right_on, ctrl_o.supply_on, ctrl_o.left_mute, ctrl_o.right_mute},
			{3'h0, e});
		if (vol[7:6] == 2'h0) begin
			cmp8({2'h0, ctrl_o.left_gain}, {2'h0, vol[5:0]});
			cmp8({2'h0, ctrl_o.right_gain}, {2'h0, vol[5:0]});
		end
	endtask : chk_ctrl
	// a hung run ends as a failure
	initial begin
		#400000;
		bad_count++;
		stop_test();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		repeat (4) @(posedge clk_i);
		chk_ctrl(3'h0, 8'hc0);
		rd(8'h80, 3'h0, 8'hc0, 6);
		@(posedge clk_i);
		#1 flags = 3'b010;
		for (int md = 0; md < 8; md++) begin
			wr(8'hc0, {1'b1, md[2:0], 4'hf}, {md[1:0], 6'h25}, 1'b1);
			chk_ctrl(md[2:0], {md[1:0], 6'h25});
			rd(8'h40, md[2:0], {md[1:0], 6'h25}, 3);
		end
		wr(8'hc0, 8'h30, 8'h00, 1'b1);
		chk_ctrl(3'h3, 8'h00);
		// neighbour address must be ignored
		wr(8'hc2, 8'h00, 8'h3f, 1'b0);
		rd(8'h40, 3'h3, 8'h00, 5);
		// master standby: bus dead, state back to defaults
		@(posedge clk_i);
		#1 standby_n_i = 1'b0;
		wr(8'hc0, 8'h30, 8'h3f, 1'b0);
		@(posedge clk_i);
		#1 standby_n_i = 1'b1;
		repeat (4) @(posedge clk_i);
		chk_ctrl(3'h0, 8'hc0);
		rd(8'h40, 3'h0, 8'hc0, 5);
		stop_test();
	end
endmodule : hpamp_i2c_ctrl_bench
`default_nettype wire
